// File: periph_gate_pkg.sv
// Constants for the peripheral module clock gate block.
package periph_gate_pkg;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] GATE_ONE_OFS   = 5'h00;
	localparam logic [ADDR_W-1:0] GATE_TWO_OFS   = 5'h04;
	localparam logic [ADDR_W-1:0] GATE_THREE_OFS = 5'h08;
	localparam logic [ADDR_W-1:0] GATE_FOUR_OFS  = 5'h0c;
	localparam logic [ADDR_W-1:0] GATE_FIVE_OFS  = 5'h10;
	localparam int NUM_REGS = 5;
	// Implemented bits of each gate register; all others read zero.
	localparam logic [31:0] GATE_ONE_MASK   = 32'h0000_1001;
	localparam logic [31:0] GATE_TWO_MASK   = 32'h0000_0003;
	localparam logic [31:0] GATE_THREE_MASK = 32'h01ff_01ff;
	localparam logic [31:0] GATE_FOUR_MASK  = 32'h0000_01ff;
	localparam logic [31:0] GATE_FIVE_MASK  = 32'h0000_0003;
	localparam logic [31:0] GATE_RESET      = 32'h0000_0000;
	localparam int ADC_BIT      = 0;
	localparam int VREF_BIT     = 12;
	localparam int CMP1_BIT     = 0;
	localparam int CMP2_BIT     = 1;
	localparam int CAPTURE_LSB  = 0;
	localparam int COMPARE_LSB  = 16;
	localparam int TIMER_LSB    = 0;
	localparam int UART1_BIT    = 0;
	localparam int UART2_BIT    = 1;
	localparam int NUM_UNITS    = 9;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: periph_gate.sv
// Peripheral module disable registers with per-peripheral clock enables.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module periph_gate
	import periph_gate_pkg::*;
#(
	parameter int UNITS = NUM_UNITS
) (
	input  wire logic              i_mclk,          // System clock, 100 MHz.
	input  wire logic              i_rst_n,         // Synchronous reset, active low.
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,    // Write address.
	input  wire logic              s_axi_awvalid,   // Write address valid.
	output logic                   s_axi_awready,   // Write address ready.
	input  wire logic [31:0]       s_axi_wdata,     // Write data.
	input  wire logic [3:0]        s_axi_wstrb,     // Write byte strobes.
	input  wire logic              s_axi_wvalid,    // Write data valid.
	output logic                   s_axi_wready,    // Write data ready.
	output logic [1:0]             s_axi_bresp,     // Write response.
	output logic                   s_axi_bvalid,    // Write response valid.
	input  wire logic              s_axi_bready,    // Write response ready.
	input  wire logic [ADDR_W-1:0] s_axi_araddr,    // Read address.
	input  wire logic              s_axi_arvalid,   // Read address valid.
	output logic                   s_axi_arready,   // Read address ready.
	output logic [31:0]            s_axi_rdata,     // Read data.
	output logic [1:0]             s_axi_rresp,     // Read response.
	output logic                   s_axi_rvalid,    // Read data valid.
	input  wire logic              s_axi_rready,    // Read data ready.
	output logic                   o_adc_clk_en,    // Converter clock enable.
	output logic                   o_vref_clk_en,   // Voltage reference clock enable.
	output logic [1:0]             o_cmp_clk_en,    // Comparator 1..2 clock enables.
	output logic [UNITS-1:0]       o_capture_clk_en, // Input capture clock enables.
	output logic [UNITS-1:0]       o_compare_clk_en, // Output compare clock enables.
	output logic [UNITS-1:0]       o_timer_clk_en,  // Timer clock enables.
	output logic [1:0]             o_uart_clk_en,   // UART 1..2 clock enables.
	output logic                   o_adc_regs_en,   // Converter register access allowed.
	output logic                   o_vref_regs_en,  // Reference register access allowed.
	output logic [1:0]             o_cmp_regs_en,   // Comparator register access allowed.
	output logic [UNITS-1:0]       o_capture_regs_en, // Capture register access allowed.
	output logic [UNITS-1:0]       o_compare_regs_en, // Compare register access allowed.
	output logic [UNITS-1:0]       o_timer_regs_en, // Timer register access allowed.
	output logic [1:0]             o_uart_regs_en   // UART register access allowed.
);
	// Units past nine would reach bits that the gate registers do not hold.
	if (UNITS < 1 || UNITS > NUM_UNITS) begin : g_bad_units
		$error("UNITS must lie between 1 and 9.");
	end

	logic [31:0]       gate_reg [NUM_REGS];
	logic [31:0]       gate_next [NUM_REGS];
	logic [31:0]       mask [NUM_REGS];
	logic [ADDR_W-1:0] awaddr_reg;
	logic              aw_held_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              w_held_reg;
	logic              bvalid_reg;
	logic              awready_reg;
	logic              wready_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;

	// Unit mask trimmed to the number of units fitted on this variant.
	localparam logic [31:0] UNIT_MASK = 32'((64'h1 << UNITS) - 64'h1);

	assign mask[0] = GATE_ONE_MASK;
	assign mask[1] = GATE_TWO_MASK;
	assign mask[2] = GATE_THREE_MASK & (UNIT_MASK | (UNIT_MASK << COMPARE_LSB));
	assign mask[3] = GATE_FOUR_MASK & UNIT_MASK;
	assign mask[4] = GATE_FIVE_MASK;

	wire              aw_take  = s_axi_awvalid && awready_reg;
	wire              w_take   = s_axi_wvalid && wready_reg;
	wire              aw_ok    = aw_held_reg || aw_take;
	wire              w_ok     = w_held_reg || w_take;
	wire              wr_fire  = aw_ok && w_ok && !bvalid_reg;
	wire              b_done   = bvalid_reg && s_axi_bready;
	wire [ADDR_W-1:0] wr_addr  = aw_held_reg ? awaddr_reg : s_axi_awaddr;
	wire [31:0]       wr_data  = w_held_reg ? wdata_reg : s_axi_wdata;
	wire [3:0]        wr_strb  = w_held_reg ? wstrb_reg : s_axi_wstrb;
	wire [31:0]       wr_bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
	                              {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire              wr_hit   = wr_addr[1:0] == 2'b00 && wr_addr[ADDR_W-1:2] < NUM_REGS;
	wire [2:0]        wr_idx   = 3'(wr_addr[ADDR_W-1:2]);
	wire              rd_fire  = s_axi_arvalid && arready_reg;
	wire              rd_hit   = s_axi_araddr[1:0] == 2'b00
	                             && s_axi_araddr[ADDR_W-1:2] < NUM_REGS;
	wire [2:0]        rd_idx   = 3'(s_axi_araddr[ADDR_W-1:2]);

	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++) begin : g_regs
			// Unassigned bits never store, so they always read zero.
			assign gate_next[g] = (wr_fire && wr_hit && wr_idx == 3'(g))
				? ((gate_reg[g] & ~wr_bmask) | (wr_data & wr_bmask)) & mask[g]
				: gate_reg[g];
			always_ff @(posedge i_mclk) begin
				if (!i_rst_n) begin
					gate_reg[g] <= GATE_RESET;
				end else begin
					gate_reg[g] <= gate_next[g];
				end
			end
		end
	endgenerate

	// The address parks here when it arrives ahead of its data.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			aw_held_reg <= 1'b0;
			awaddr_reg  <= '0;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end else if (aw_take) begin
			aw_held_reg <= 1'b1;
			awaddr_reg  <= s_axi_awaddr;
		end
	end

	// The data word parks here when it arrives ahead of its address.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			w_held_reg <= 1'b0;
			wdata_reg  <= '0;
			wstrb_reg  <= '0;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end else if (w_take) begin
			w_held_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata;
			wstrb_reg  <= s_axi_wstrb;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (b_done) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Ready drops once a word is parked or answered, so nothing is taken without a handshake.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
		end else if (b_done) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
		end else begin
			awready_reg <= awready_reg && !aw_take;
			wready_reg  <= wready_reg && !w_take;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	wire [31:0]       rd_word  = rd_hit ? gate_reg[rd_idx] : 32'h0000_0000;
	wire [1:0]        rd_resp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
	wire              r_done   = rvalid_reg && s_axi_rready;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end else if (rd_fire) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
		end else if (r_done) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	// Read data is captured once per address and held until the master takes it.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else if (rd_fire) begin
			rdata_reg <= rd_word;
			rresp_reg <= rd_resp;
		end
	end

	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// Run levels come from the next register value so the enables move on the write edge.
	wire              adc_on   = !gate_next[0][ADC_BIT];
	wire              vref_on  = !gate_next[0][VREF_BIT];
	wire [1:0]        cmp_on   = ~{gate_next[1][CMP2_BIT], gate_next[1][CMP1_BIT]};
	wire [1:0]        uart_on  = ~{gate_next[4][UART2_BIT], gate_next[4][UART1_BIT]};
	wire [UNITS-1:0]  capture_on;
	wire [UNITS-1:0]  compare_on;
	wire [UNITS-1:0]  timer_on;

	genvar u;
	generate
		for (u = 0; u < UNITS; u++) begin : g_units
			assign capture_on[u] = !gate_next[2][CAPTURE_LSB + u];
			assign compare_on[u] = !gate_next[2][COMPARE_LSB + u];
			assign timer_on[u]   = !gate_next[3][TIMER_LSB + u];
		end
	endgenerate

	// The peripheral bus bridge drops writes and returns junk reads when a regs enable is low.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_adc_clk_en  <= 1'b1;
			o_adc_regs_en <= 1'b1;
		end else begin
			o_adc_clk_en  <= adc_on;
			o_adc_regs_en <= adc_on;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_vref_clk_en  <= 1'b1;
			o_vref_regs_en <= 1'b1;
		end else begin
			o_vref_clk_en  <= vref_on;
			o_vref_regs_en <= vref_on;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_cmp_clk_en  <= '1;
			o_cmp_regs_en <= '1;
		end else begin
			o_cmp_clk_en  <= cmp_on;
			o_cmp_regs_en <= cmp_on;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_capture_clk_en  <= '1;
			o_capture_regs_en <= '1;
		end else begin
			o_capture_clk_en  <= capture_on;
			o_capture_regs_en <= capture_on;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_compare_clk_en  <= '1;
			o_compare_regs_en <= '1;
		end else begin
			o_compare_clk_en  <= compare_on;
			o_compare_regs_en <= compare_on;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_timer_clk_en  <= '1;
			o_timer_regs_en <= '1;
		end else begin
			o_timer_clk_en  <= timer_on;
			o_timer_regs_en <= timer_on;
		end
	end

	// A stopped UART loses any frame in flight; software must idle it before gating.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_uart_clk_en  <= '1;
			o_uart_regs_en <= '1;
		end else begin
			o_uart_clk_en  <= uart_on;
			o_uart_regs_en <= uart_on;
		end
	end
endmodule

// File: periph_gate_assertions.sv
// Handshake and gating checks for the peripheral clock gate block.
`timescale 1ns/10ps
module periph_gate_assertions (
	input wire logic       i_mclk,         // Clock.
	input wire logic       i_rst_n,        // Reset.
	input wire logic       s_axi_awvalid,  // Aw valid.
	input wire logic       s_axi_awready,  // Aw ready.
	input wire logic       s_axi_wvalid,   // W valid.
	input wire logic       s_axi_wready,   // W ready.
	input wire logic       s_axi_bvalid,   // B valid.
	input wire logic       s_axi_bready,   // B ready.
	input wire logic       s_axi_arvalid,  // Ar valid.
	input wire logic       s_axi_arready,  // Ar ready.
	input wire logic       s_axi_rvalid,   // R valid.
	input wire logic       s_axi_rready,   // R ready.
	input wire logic       o_adc_clk_en,   // Converter clock.
	input wire logic       o_adc_regs_en,  // Converter access.
	input wire logic [1:0] o_uart_clk_en,  // UART clocks.
	input wire logic [1:0] o_uart_regs_en  // UART access.
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	property p_mirror; o_uart_regs_en == o_uart_clk_en && o_adc_regs_en == o_adc_clk_en; endproperty
	a_mirror: assert property (p_mirror) else $error("access differs from clock");
	// Gating may only move with a completed write, never on its own.
	property p_moves; !$stable(o_uart_clk_en) || !$stable(o_adc_clk_en) |-> $rose(s_axi_bvalid); endproperty
	a_moves: assert property (p_moves) else $error("enable moved without write");
	property p_open; $rose(i_rst_n) |-> o_adc_clk_en && o_uart_clk_en == 2'h3; endproperty
	a_open: assert property (p_open) else $error("gated after reset");
	property p_wans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
	a_wans: assert property (p_wans) else $error("no write response");
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdone: assert property (p_bdone) else $error("write response repeated");
	property p_bblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_bblock: assert property (p_bblock) else $error("write taken while answering");
	property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_rans: assert property (p_rans) else $error("no read data");
	property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
	a_rdone: assert property (p_rdone) else $error("read not closed");
endmodule
bind periph_gate periph_gate_assertions u_periph_gate_assertions (.*);

// File: tb.sv
// Self-checking bench for the peripheral clock gate block.
`timescale 1ns/10ps
module tb;
	import periph_gate_pkg::*;
	logic              i_mclk = 1'h0, i_rst_n = 1'h0;
	logic [ADDR_W-1:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00, a;
	logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'hf, sv;
	logic [31:0]       dv;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp, o_cmp_clk_en, o_uart_clk_en, o_cmp_regs_en;
	logic [1:0]        o_uart_regs_en;
	logic              o_adc_clk_en, o_vref_clk_en, o_adc_regs_en, o_vref_regs_en;
	logic [8:0]        o_capture_clk_en, o_compare_clk_en, o_timer_clk_en;
	logic [8:0]        o_capture_regs_en, o_compare_regs_en, o_timer_regs_en;
	logic [31:0]       mdl [5];
	logic [31:0]       msk [5] = '{GATE_ONE_MASK, GATE_TWO_MASK, GATE_THREE_MASK,
	                               GATE_FOUR_MASK, GATE_FIVE_MASK};
	int                err_count = 0, samples_checked = 0, seed = 51007, i;
	wire  [32:0]       clk_en = {o_adc_clk_en, o_vref_clk_en, o_cmp_clk_en, o_uart_clk_en,
	                             o_capture_clk_en, o_compare_clk_en, o_timer_clk_en};
	wire  [32:0]       reg_en = {o_adc_regs_en, o_vref_regs_en, o_cmp_regs_en, o_uart_regs_en,
	                             o_capture_regs_en, o_compare_regs_en, o_timer_regs_en};
	periph_gate u_periph_gate (.*);
	always #5 i_mclk = ~i_mclk;
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
	                                      input logic [3:0] st);
		logic [31:0] m;
		m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
		return (o & ~m) | (d & m);
	endfunction
	function automatic logic [32:0] exp_en();
		return ~{mdl[0][0], mdl[0][12], mdl[1][1:0], mdl[4][1:0], mdl[2][8:0], mdl[2][24:16],
		         mdl[3][8:0]};
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_en(input string n, input logic [32:0] e, input logic [32:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] ad, input logic [31:0] d, input logic [3:0] st,
	                  output logic [1:0] r);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge i_mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [4:0] ad, output logic [31:0] q, output logic [1:0] r);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge i_mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				q = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'h0;
				break;
			end
		end
	endtask
	// Write, check response and gating, then read the same place back.
	task automatic step(input logic [4:0] ad, input logic [31:0] d, input logic [3:0] st);
		logic [1:0]  r;
		logic [31:0] q;
		logic        ok;
		ok = ad[1:0] == 2'h0 && ad[4:2] < 3'h5;
		wr(ad, d, st, r);
		if (ok) mdl[ad[4:2]] = merge(mdl[ad[4:2]], d, st) & msk[ad[4:2]];
		chk("bresp", {30'h0, ok ? RESP_OKAY : RESP_SLVERR}, {30'h0, r});
		chk_en("clk_en", exp_en(), clk_en);
		chk_en("regs_en", exp_en(), reg_en);
		rd(ad, q, r);
		chk("rresp", {30'h0, ok ? RESP_OKAY : RESP_SLVERR}, {30'h0, r});
		chk("rdata", ok ? mdl[ad[4:2]] : 32'h0, q);
	endtask
	task automatic rst_chk();
		logic [31:0] q;
		logic [1:0]  r;
		i_rst_n <= 1'h0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'h1;
		for (int j = 0; j < 5; j++) begin
			mdl[j] = GATE_RESET;
			rd(5'(j * 4), q, r);
			chk("reset rdata", 32'h0, q);
			@(posedge i_mclk);
		end
		chk_en("reset clk_en", 33'h1_ffff_ffff, clk_en);
		chk_en("reset regs_en", 33'h1_ffff_ffff, reg_en);
		$display("test reset done");
	endtask
	initial begin
		#50000;
		err_count++;
		wrap_up();
	end
	initial begin
		rst_chk();
		// The bench acts as software whose peripherals are all idle with their on bits clear.
		for (i = 0; i < 10; i++) begin
			step(5'((i % 5) * 4), i < 5 ? 32'hffffffff : 32'h0, 4'hf);
		end
		$display("test corners done");
		repeat (40) begin
			a = 5'($random(seed));
			dv = $random(seed);
			sv = 4'($random(seed));
			step(a, dv, sv);
		end
		$display("test random done");
		rst_chk();
		wrap_up();
	end
endmodule
